// ---- hdl/fer_pkg.sv ----
// Shared constants and types of the 100 Mb/s receive coding path.
// Assumes one core clock at CLK_MHZ and one received symbol per accepted cycle.
package fer_pkg;

	// ---------------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------------
	localparam int CLK_MHZ          = 25;
	localparam int HOLD_TIME_US     = 722;
	localparam int LINK_TIME_US     = 395;
	localparam int HOLD_CYCLES      = HOLD_TIME_US * CLK_MHZ;
	localparam int LINK_CYCLES      = LINK_TIME_US * CLK_MHZ;
	localparam int LOCK_IDLE_GROUPS = 12;
	localparam int GROUP_BITS       = 5;
	localparam int LOCK_IDLE_BITS   = LOCK_IDLE_GROUPS * GROUP_BITS;
	localparam int HOLD_IDLE_BITS   = 58;
	localparam int END_IDLE_GROUPS  = 2;
	localparam int FIFO_DEPTH       = 8;

	// ---------------------------------------------------------------------
	// Code-groups and nibbles
	// ---------------------------------------------------------------------
	localparam logic [4:0] CG_IDLE  = 5'h1f;
	localparam logic [4:0] CG_J     = 5'h18;
	localparam logic [4:0] CG_K     = 5'h11;
	localparam logic [4:0] CG_T     = 5'h0d;
	localparam logic [4:0] CG_R     = 5'h07;
	localparam logic [4:0] CG_HALT  = 5'h04;
	localparam logic [3:0] NIB_PRE  = 4'h5;
	localparam logic [3:0] NIB_BAD  = 4'he;
	localparam logic [3:0] NIB_NONE = 4'h0;

	// ---------------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------------
	localparam logic [10:0] KEY_RESET   = 11'h000;
	localparam logic [14:0] SHIFT_RESET = 15'h0000;
	localparam logic [15:0] FCC_RESET   = 16'h0000;

	typedef enum logic [2:0] {
		ST_SEARCH = 3'b000,
		ST_PRE    = 3'b001,
		ST_DATA   = 3'b010,
		ST_TR     = 3'b011,
		ST_BAD    = 3'b100
	} fer_state_e;

	typedef struct packed {
		logic       dv;
		logic       er;
		logic       crs;
		logic [3:0] rxd;
	} fer_mii_s;

endpackage

// ---- hdl/fer_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes the same clock and reset as the receive path.
module fer_fifo #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out,
	// Status
	output logic [$clog2(DEPTH):0] level_out
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_check
			$error("fer_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              do_wr = in_valid_in & in_ready_out;
	wire              do_rd = out_valid_out & out_ready_in;

	assign in_ready_out  = (count != DEPTH[AW:0]);
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];
	assign level_out     = count;

	always_ff @(posedge clk_in)
	begin
		if (do_wr)
			mem[wr_ptr] <= in_data_in;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		end
	end

endmodule

// ---- hdl/fer_rx_path.sv ----
// Receive coding path: MLT-3 symbols in, MII-style nibbles out through a FIFO.
// Assumes one MLT-3 level per accepted cycle and inputs synchronous to core_clk_in.
//
// Operation
// - Signal detect is ignored while 10 Mb/s or negotiation link pulses arrive.
// - MLT-3 levels are turned into a binary NRZI bit stream.
// - NRZI becomes NRZ, a transition meaning one, before descrambling.
// - Received bits are gathered into 5-bit symbols for the decoder.
// - A key identical to the transmitter's is XORed onto each received bit.
// - Lock is declared after 12 consecutive descrambled IDLE groups.
// - Lock starts a 722 us hold countdown.
// - 58 bit times of IDLE within the period reload the countdown.
// - Countdown expiry drops lock and resets the descrambler fully.
// - J/K 11000 10001 sets a fixed 5-bit boundary for later symbols.
// - With descrambling bypassed the aligner takes raw NRZ bits.
// - Each aligned group is turned into a nibble by table lookup.
// - J/K after IDLE yields nibbles 0101 0101, then packet data follows.
// - Decoding stops on T/R or on two consecutive IDLE groups.
// - Link comes up after 395 us of continuous signal detect, enabling PCS.
// - Leaving IDLE without a J/K prefix is a bad start of stream.
// - During bad start, error with nibble 1110 per group until two IDLEs.
// - Each bad start adds one to the false carrier event counter.
// - After two IDLE groups the error and carrier sense are dropped.
// - Data groups map to nibbles per the 4B/5B table; control codes fixed.
// - Control or undefined groups inside a packet decode as errors.
// - The key generator is an 11-bit shift register, fed from the line until lock and closed-loop once locked.
module fer_rx_path #(
	parameter int HOLD_CYCLES = fer_pkg::HOLD_CYCLES,
	parameter int LINK_CYCLES = fer_pkg::LINK_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       resetn_in,
	// Equaliser side
	input  wire logic [1:0] sym_in,
	input  wire logic       sym_valid_in,
	output logic            sym_ready_out,
	input  wire logic       signal_detect_in,
	input  wire logic       link_pulse_in,
	// Control
	input  wire logic       descramble_bypass_in,
	// MAC side
	output logic            rx_valid_out,
	input  wire logic       mac_ready_in,
	output logic            rx_dv_out,
	output logic            rx_er_out,
	output logic            crs_out,
	output logic [3:0]      rxd_out,
	// Status
	output logic            link_up_out,
	output logic            pcs_enable_out,
	output logic            scr_locked_out,
	output logic [15:0]     false_carrier_event_counter_out
);

	generate
		if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535 || LINK_CYCLES < 1 || LINK_CYCLES > 65535)
		begin : g_check
			$error("fer_rx_path timer counts must lie in 1..65535");
		end
	endgenerate

	localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYCLES);
	localparam logic [15:0] LINK_LOAD = 16'(LINK_CYCLES - 1);
	localparam logic [5:0]  LOCK_LAST = 6'(fer_pkg::LOCK_IDLE_BITS - 1);
	localparam logic [5:0]  HOLD_LAST = 6'(fer_pkg::HOLD_IDLE_BITS - 1);
	localparam logic [2:0]  GRP_LAST  = 3'(fer_pkg::GROUP_BITS - 1);
	localparam logic [1:0]  IDLE_END  = 2'(fer_pkg::END_IDLE_GROUPS);
	localparam logic [9:0]  JK_PAIR   = {fer_pkg::CG_J, fer_pkg::CG_K};

	// -------------------------------------------------------------------------
	// Signal detect and link monitor
	// -------------------------------------------------------------------------
	logic [15:0] sd_count;
	logic        link_up;
	wire         sd_valid = signal_detect_in & ~link_pulse_in;

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sd_count <= '0;
			link_up  <= 1'b0;
		end
		else if (!sd_valid)
		begin
			sd_count <= '0;
			link_up  <= 1'b0;
		end
		else if (sd_count == LINK_LOAD)
			link_up <= 1'b1;
		else
			sd_count <= sd_count + 16'h0001;
	end

	// -------------------------------------------------------------------------
	// Symbol acceptance
	// -------------------------------------------------------------------------
	// A packet emits at most one entry per bit, so two free slots keep the
	// registered ready honest without a combinational path to the FIFO.
	logic [3:0] fifo_level;
	logic       fifo_in_ready;
	wire        bit_en = sym_valid_in & sym_ready_out & fifo_in_ready;

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			sym_ready_out <= 1'b0;
		else
			sym_ready_out <= (fifo_level < 4'(fer_pkg::FIFO_DEPTH - 2));
	end

	// -------------------------------------------------------------------------
	// MLT-3 to NRZI to NRZ
	// -------------------------------------------------------------------------
	logic [1:0] prev_level;
	logic       nrzi;
	logic       nrzi_d;
	wire        nrz = nrzi ^ nrzi_d;

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			prev_level <= 2'h0;
			nrzi       <= 1'b0;
			nrzi_d     <= 1'b0;
		end
		else if (bit_en)
		begin
			prev_level <= sym_in;
			nrzi       <= nrzi ^ (sym_in != prev_level);
			nrzi_d     <= nrzi;
		end
	end

	// -------------------------------------------------------------------------
	// Descrambler, lock and hold timer
	// -------------------------------------------------------------------------
	logic [10:0] key_reg;
	logic [5:0]  ones_run;
	logic        locked;
	logic [15:0] hold_timer;
	wire         key_bit  = key_reg[10] ^ key_reg[8];
	wire         plain    = nrz ^ key_bit;
	wire         hold_hit = bit_en & plain & (ones_run >= HOLD_LAST);
	wire         lose     = ~link_up | (locked & (hold_timer == 16'h0000));
	wire [10:0]  next_key = locked ? {key_reg[9:0], key_bit} : {key_reg[9:0], ~nrz};

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			key_reg    <= fer_pkg::KEY_RESET;
			ones_run   <= '0;
			locked     <= 1'b0;
			hold_timer <= '0;
		end
		else if (lose)
		begin
			key_reg    <= fer_pkg::KEY_RESET;
			ones_run   <= '0;
			locked     <= 1'b0;
			hold_timer <= '0;
		end
		else
		begin
			if (bit_en)
			begin
				key_reg  <= next_key;
				ones_run <= !plain ? 6'h00 : (ones_run == 6'h3f) ? ones_run : ones_run + 6'h01;
			end
			if (!locked && bit_en && plain && ones_run == LOCK_LAST)
			begin
				locked     <= 1'b1;
				hold_timer <= HOLD_LOAD;
			end
			else if (locked && hold_hit)
				hold_timer <= HOLD_LOAD;
			else if (locked)
				hold_timer <= hold_timer - 16'h0001;
		end
	end

	// -------------------------------------------------------------------------
	// Code-group alignment
	// -------------------------------------------------------------------------
	logic [14:0] shift;
	wire         path_ok    = link_up & (locked | descramble_bypass_in);
	wire         align_bit  = descramble_bypass_in ? nrz : plain;
	wire [14:0]  next_shift = {shift[13:0], align_bit};
	wire [4:0]   group      = next_shift[4:0];
	// The first zero after IDLE has just reached the J slot's third bit.
	wire         leave_idle = ~next_shift[7] & (&next_shift[14:8]);
	wire         jk_seen    = leave_idle & (next_shift[9:0] == JK_PAIR);

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			shift <= fer_pkg::SHIFT_RESET;
		else if (bit_en)
			shift <= next_shift;
	end

	// -------------------------------------------------------------------------
	// 4B/5B lookup
	// -------------------------------------------------------------------------
	function automatic logic [4:0] decode_group(input logic [4:0] cg);
		logic [4:0] r;
		r = {1'b0, fer_pkg::NIB_NONE};
		case (cg)
			5'h1e: r = 5'h10;
			5'h09: r = 5'h11;
			5'h14: r = 5'h12;
			5'h15: r = 5'h13;
			5'h0a: r = 5'h14;
			5'h0b: r = 5'h15;
			5'h0e: r = 5'h16;
			5'h0f: r = 5'h17;
			5'h12: r = 5'h18;
			5'h13: r = 5'h19;
			5'h16: r = 5'h1a;
			5'h17: r = 5'h1b;
			5'h1a: r = 5'h1c;
			5'h1b: r = 5'h1d;
			5'h1c: r = 5'h1e;
			5'h1d: r = 5'h1f;
			default: r = {1'b0, fer_pkg::NIB_NONE};
		endcase
		return r;
	endfunction

	// -------------------------------------------------------------------------
	// Receive state machine
	// -------------------------------------------------------------------------
	fer_pkg::fer_state_e state;
	fer_pkg::fer_state_e next_state;
	logic [2:0]          phase;
	logic [2:0]          next_phase;
	logic [1:0]          idle_cnt;
	logic [1:0]          next_idle_cnt;
	logic                wr_valid;
	fer_pkg::fer_mii_s   wr_data;
	logic                fc_inc;
	wire  [4:0]          lookup    = decode_group(group);
	wire                 grp_done  = (phase == GRP_LAST);
	wire                 grp_idle  = (group == fer_pkg::CG_IDLE);
	wire  [1:0]          idle_step = grp_idle ? idle_cnt + 2'h1 : 2'h0;

	always_comb
	begin
		next_state    = state;
		next_phase    = grp_done ? 3'h0 : phase + 3'h1;
		next_idle_cnt = idle_cnt;
		wr_valid      = 1'b0;
		wr_data       = '{dv: 1'b0, er: 1'b0, crs: 1'b0, rxd: fer_pkg::NIB_NONE};
		fc_inc        = 1'b0;
		case (state)
			fer_pkg::ST_SEARCH:
			begin
				next_phase = 3'h0;
				if (jk_seen)
				begin
					next_state = fer_pkg::ST_PRE;
					wr_valid   = 1'b1;
					wr_data    = '{dv: 1'b1, er: 1'b0, crs: 1'b1, rxd: fer_pkg::NIB_PRE};
				end
				else if (leave_idle)
				begin
					next_state    = fer_pkg::ST_BAD;
					next_idle_cnt = 2'h0;
					fc_inc        = 1'b1;
					wr_valid      = 1'b1;
					wr_data       = '{dv: 1'b0, er: 1'b1, crs: 1'b1, rxd: fer_pkg::NIB_BAD};
				end
			end
			fer_pkg::ST_PRE:
			begin
				next_state    = fer_pkg::ST_DATA;
				next_idle_cnt = 2'h0;
				wr_valid      = 1'b1;
				wr_data       = '{dv: 1'b1, er: 1'b0, crs: 1'b1, rxd: fer_pkg::NIB_PRE};
			end
			fer_pkg::ST_DATA, fer_pkg::ST_TR:
			begin
				if (grp_done)
				begin
					next_idle_cnt = idle_step;
					wr_valid      = 1'b1;
					if ((state == fer_pkg::ST_TR && group == fer_pkg::CG_R) || idle_step == IDLE_END)
						next_state = fer_pkg::ST_SEARCH;
					else if (group == fer_pkg::CG_T)
					begin
						next_state = fer_pkg::ST_TR;
						wr_valid   = 1'b0;
					end
					else
					begin
						next_state = fer_pkg::ST_DATA;
						wr_data    = '{dv: 1'b1, er: ~lookup[4], crs: 1'b1, rxd: lookup[3:0]};
					end
				end
			end
			fer_pkg::ST_BAD:
			begin
				if (grp_done)
				begin
					next_idle_cnt = idle_step;
					wr_valid      = 1'b1;
					if (idle_step == IDLE_END)
						next_state = fer_pkg::ST_SEARCH;
					else
						wr_data = '{dv: 1'b0, er: 1'b1, crs: 1'b1, rxd: fer_pkg::NIB_BAD};
				end
			end
			default:
			begin
				next_state = fer_pkg::ST_SEARCH;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state    <= fer_pkg::ST_SEARCH;
			phase    <= '0;
			idle_cnt <= '0;
		end
		else if (!path_ok)
		begin
			state    <= fer_pkg::ST_SEARCH;
			phase    <= '0;
			idle_cnt <= '0;
		end
		else if (bit_en)
		begin
			state    <= next_state;
			phase    <= next_phase;
			idle_cnt <= next_idle_cnt;
		end
	end

	// -------------------------------------------------------------------------
	// Counter, FIFO and registered MAC outputs
	// -------------------------------------------------------------------------
	logic              fifo_out_valid;
	fer_pkg::fer_mii_s fifo_out;
	wire               out_take = ~rx_valid_out | mac_ready_in;
	wire               fifo_wr  = bit_en & path_ok & wr_valid;

	fer_fifo #(
		.WIDTH($bits(fer_pkg::fer_mii_s)),
		.DEPTH(fer_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in       (core_clk_in),
		.resetn_in    (resetn_in),
		.in_valid_in  (fifo_wr),
		.in_ready_out (fifo_in_ready),
		.in_data_in   (wr_data),
		.out_valid_out(fifo_out_valid),
		.out_ready_in (out_take),
		.out_data_out (fifo_out),
		.level_out    (fifo_level)
	);

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			false_carrier_event_counter_out <= fer_pkg::FCC_RESET;
			rx_valid_out   <= 1'b0;
			rx_dv_out      <= 1'b0;
			rx_er_out      <= 1'b0;
			crs_out        <= 1'b0;
			rxd_out        <= fer_pkg::NIB_NONE;
			link_up_out    <= 1'b0;
			pcs_enable_out <= 1'b0;
			scr_locked_out <= 1'b0;
		end
		else
		begin
			if (bit_en && path_ok && fc_inc)
				false_carrier_event_counter_out <= false_carrier_event_counter_out + 16'h0001;
			if (out_take)
			begin
				rx_valid_out <= fifo_out_valid;
				if (fifo_out_valid)
				begin
					rx_dv_out <= fifo_out.dv;
					rx_er_out <= fifo_out.er;
					crs_out   <= fifo_out.crs;
					rxd_out   <= fifo_out.rxd;
				end
			end
			link_up_out    <= link_up;
			pcs_enable_out <= link_up;
			scr_locked_out <= locked;
		end
	end

endmodule

// ---- test/fer_rx_path_asserts.sv ----
// Checker for the receive coding path, bound to its top module.
// Assumes only the top ports and the two count parameters of the design.
module fer_rx_path_chk #(
	parameter int HOLD_CYCLES = fer_pkg::HOLD_CYCLES,
	parameter int LINK_CYCLES = fer_pkg::LINK_CYCLES
) (
	// Clock and reset
	input wire logic        core_clk_in,
	input wire logic        resetn_in,
	// Equaliser side
	input wire logic        sym_valid_in,
	input wire logic        sym_ready_out,
	input wire logic        signal_detect_in,
	input wire logic        link_pulse_in,
	// MAC side
	input wire logic        rx_valid_out,
	input wire logic        mac_ready_in,
	input wire logic        rx_dv_out,
	input wire logic        rx_er_out,
	input wire logic        crs_out,
	input wire logic [3:0]  rxd_out,
	// Status
	input wire logic        link_up_out,
	input wire logic        pcs_enable_out,
	input wire logic        scr_locked_out,
	input wire logic [15:0] false_carrier_event_counter_out
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);

	// ---------------------------------------------------------------------
	// Helper counters
	// ---------------------------------------------------------------------
	// Both saturate just above their limit so that long runs cannot wrap.
	int sd_cnt;
	int quiet_cnt;
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sd_cnt <= 0;
			quiet_cnt <= 0;
		end
		else
		begin
			sd_cnt <= (signal_detect_in && !link_pulse_in) ? ((sd_cnt > LINK_CYCLES + 4) ? sd_cnt : sd_cnt + 1) : 0;
			quiet_cnt <= (sym_valid_in && sym_ready_out) ? 0 : ((quiet_cnt > HOLD_CYCLES + 4) ? quiet_cnt : quiet_cnt + 1);
		end
	end

	// ---------------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------------
	a_link_masked: assert property (!signal_detect_in || link_pulse_in |=> ##1 !link_up_out)
		else $error("link up while signal detect invalid");
	a_link_pcs_same: assert property (link_up_out == pcs_enable_out)
		else $error("pcs enable differs from link state");
	a_link_wait: assert property ($rose(link_up_out) |-> sd_cnt >= LINK_CYCLES)
		else $error("link up before signal detect time");
	a_link_prompt: assert property (sd_cnt > LINK_CYCLES + 3 |-> link_up_out)
		else $error("link not up after signal detect time");
	a_lock_link: assert property (!link_up_out [*3] |-> !scr_locked_out)
		else $error("descrambler locked while link down");
	a_lock_expiry: assert property (quiet_cnt > HOLD_CYCLES + 3 |-> !scr_locked_out)
		else $error("lock kept past hold countdown");
	a_fcc_step: assert property ($changed(false_carrier_event_counter_out) |-> false_carrier_event_counter_out == $past(false_carrier_event_counter_out) + 16'h1)
		else $error("false carrier counter moved by other than one");
	a_bad_nibble: assert property (rx_valid_out && !rx_dv_out && crs_out |-> rx_er_out && rxd_out == fer_pkg::NIB_BAD)
		else $error("bad start entry without error nibble");
	a_end_quiet: assert property (rx_valid_out && !crs_out |-> !rx_er_out)
		else $error("error reported without carrier");
	a_entry_hold: assert property (rx_valid_out && !mac_ready_in |=> rx_valid_out && $stable({rx_dv_out, rx_er_out, crs_out, rxd_out}))
		else $error("entry changed before being taken");
endmodule

// ---- test/fer_mac_model.sv ----
// MAC model on the entry port: prompt, slow or stalled ready, records entries.
// Assumes the receive path clock and that an entry is taken when valid and ready meet.
module fer_mac_model (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	// Entry port
	input  wire logic              rx_valid_in,
	input  wire fer_pkg::fer_mii_s entry_in,
	output logic                   mac_ready_out = 1'b0,
	// Ready pattern: 0 prompt, 1 every third cycle, 2 stalled
	input  wire logic [1:0]        mode_in
);
	timeunit 1ns;
	timeprecision 1ps;

	fer_pkg::fer_mii_s got[$];
	int                tick = 0;

	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			mac_ready_out <= 1'b0;
		else
		begin
			if (rx_valid_in && mac_ready_out)
				got.push_back(entry_in);
			tick++;
			mac_ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && tick % 3 == 0);
		end
	end
endmodule

// ---- test/fer_rx_path_test.sv ----
// Self-checking bench for the receive coding path with the MAC model on its entry port.
// Assumes the package constants and short hold and link counts set below.
module fer_rx_path_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int HOLD = 400;
	localparam int LINK = 20;
	localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

	logic              core_clk_in = 1'b0;
	logic              resetn_in = 1'b0;
	logic [1:0]        sym_in = 2'h0;
	logic              sym_valid_in = 1'b0;
	logic              signal_detect_in = 1'b0;
	logic              link_pulse_in = 1'b0;
	logic              descramble_bypass_in = 1'b0;
	logic [1:0]        mac_mode = 2'h0;
	logic              mac_ready_in;
	logic              sym_ready_out;
	logic              rx_valid_out;
	logic              rx_dv_out;
	logic              rx_er_out;
	logic              crs_out;
	logic [3:0]        rxd_out;
	logic              link_up_out;
	logic              pcs_enable_out;
	logic              scr_locked_out;
	logic [15:0]       fcc;
	logic [10:0]       key = 11'h5a5;
	logic [13:0]       exp_q[$];
	fer_pkg::fer_mii_s got[$];
	int                phase = 0;
	int                err_count = 0;
	int                total_checks = 0;
	int                cycles = 0;

	fer_rx_path #(.HOLD_CYCLES(HOLD), .LINK_CYCLES(LINK)) fer_rx_path_inst (
		.core_clk_in(core_clk_in), .resetn_in(resetn_in), .sym_in(sym_in), .sym_valid_in(sym_valid_in),
		.sym_ready_out(sym_ready_out), .signal_detect_in(signal_detect_in), .link_pulse_in(link_pulse_in),
		.descramble_bypass_in(descramble_bypass_in), .rx_valid_out(rx_valid_out), .mac_ready_in(mac_ready_in),
		.rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out), .crs_out(crs_out), .rxd_out(rxd_out),
		.link_up_out(link_up_out), .pcs_enable_out(pcs_enable_out), .scr_locked_out(scr_locked_out),
		.false_carrier_event_counter_out(fcc));

	fer_mac_model fer_mac_model_inst (.clk_in(core_clk_in), .resetn_in(resetn_in), .rx_valid_in(rx_valid_out),
		.entry_in({rx_dv_out, rx_er_out, crs_out, rxd_out}), .mac_ready_out(mac_ready_in), .mode_in(mac_mode));

	always #20 core_clk_in = ~core_clk_in;

	always @(posedge core_clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			close_out();
		end
	end

	// ---------------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Scrambles one bit unless bypassed, then steps the three-level line on a one.
	task automatic send_bit(input logic ud);
		logic sd;
		int   n = 0;
		sd = descramble_bypass_in ? ud : (ud ^ key[10] ^ key[8]);
		key = {key[9:0], key[10] ^ key[8]};
		if (sd)
			phase = (phase + 1) % 4;
		sym_in <= (phase == 1) ? 2'h1 : ((phase == 3) ? 2'h3 : 2'h0);
		sym_valid_in <= 1'b1;
		do
		begin
			@(posedge core_clk_in);
			n++;
		end
		while (sym_ready_out !== 1'b1 && n < 500);
		if (n >= 500)
			check("symbol taken", 16'h0, 16'h1);
	endtask

	task automatic send_grp(input logic [4:0] g);
		for (int i = 4; i >= 0; i--)
			send_bit(g[i]);
	endtask

	task automatic send_idle(input int n);
		repeat (n) send_grp(fer_pkg::CG_IDLE);
	endtask

	task automatic pause(input int n);
		sym_valid_in <= 1'b0;
		repeat (n) @(posedge core_clk_in);
	endtask

	task automatic send_frame(input int n);
		exp_q.push_back({7'h7f, 7'h55});
		exp_q.push_back({7'h7f, 7'h55});
		send_idle(4);
		send_grp(fer_pkg::CG_J);
		send_grp(fer_pkg::CG_K);
		for (int d = 0; d < n; d++)
		begin
			send_grp(CODE[d]);
			exp_q.push_back({7'h7f, 7'h50 | 7'(d)});
		end
	endtask

	task automatic send_end();
		send_grp(fer_pkg::CG_T);
		send_grp(fer_pkg::CG_R);
		exp_q.push_back({7'h7f, 7'h00});
		send_idle(3);
	endtask

	task automatic match(input string what);
		int n = 0;
		pause(0);
		while (fer_mac_model_inst.got.size() < exp_q.size() && n < 400)
		begin
			@(posedge core_clk_in);
			n++;
		end
		repeat (10) @(posedge core_clk_in);
		got = fer_mac_model_inst.got;
		check({what, " count"}, 16'(got.size()), 16'(exp_q.size()));
		for (int i = 0; i < exp_q.size() && i < got.size(); i++)
			check(what, 16'(got[i] & exp_q[i][13:7]), 16'(exp_q[i][6:0]));
		exp_q.delete();
		fer_mac_model_inst.got.delete();
		$display("done %s", what);
	endtask

	// ---------------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------------
	task automatic t_link();
		signal_detect_in <= 1'b1;
		link_pulse_in <= 1'b1;
		repeat (40) @(posedge core_clk_in);
		check("link under pulses", 16'(link_up_out), 16'h0);
		link_pulse_in <= 1'b0;
		repeat (LINK - 4) @(posedge core_clk_in);
		check("link early", 16'(link_up_out), 16'h0);
		repeat (8) @(posedge core_clk_in);
		check("link up", 16'(link_up_out), 16'h1);
		check("pcs enable", 16'(pcs_enable_out), 16'h1);
		$display("done link");
	endtask

	task automatic t_lock();
		send_idle(8);
		check("lock early", 16'(scr_locked_out), 16'h0);
		send_idle(22);
		check("lock", 16'(scr_locked_out), 16'h1);
		send_idle(120);
		check("lock held by idle", 16'(scr_locked_out), 16'h1);
		pause(HOLD - 40);
		check("lock in countdown", 16'(scr_locked_out), 16'h1);
		pause(60);
		check("lock dropped", 16'(scr_locked_out), 16'h0);
		send_idle(30);
		check("relock", 16'(scr_locked_out), 16'h1);
		send_frame(4);
		send_end();
		match("scrambled packet");
	endtask

	// The stalled MAC lets the FIFO fill until symbols are refused.
	task automatic t_fill();
		int n;
		send_bit(~key[10] ^ key[8]);
		descramble_bypass_in <= 1'b1;
		mac_mode <= 2'h2;
		pause(2);
		fork
			begin
				send_frame(16);
				send_end();
			end
			begin
				n = 0;
				while (sym_ready_out !== 1'b0 && n < 300)
				begin
					@(posedge core_clk_in);
					n++;
				end
				check("fifo refusal", 16'(sym_ready_out), 16'h0);
				repeat (20) @(posedge core_clk_in);
				mac_mode <= 2'h1;
			end
		join
		match("full table");
		check("fifo drained", 16'(rx_valid_out), 16'h0);
	endtask

	task automatic t_halt();
		send_frame(1);
		send_grp(fer_pkg::CG_HALT);
		exp_q.push_back({7'h70, 7'h70});
		send_grp(fer_pkg::CG_IDLE);
		exp_q.push_back({7'h70, 7'h70});
		exp_q.push_back({7'h7f, 7'h00});
		send_idle(3);
		match("control in data");
	endtask

	task automatic t_bad();
		logic [15:0] base;
		base = fcc;
		for (int k = 0; k < 2; k++)
		begin
			send_idle(4);
			send_grp(k ? 5'h1c : 5'h1a);
			send_grp(5'h1a);
			send_idle(3);
			pause(40);
			got = fer_mac_model_inst.got;
			check("bad start entries", 16'(got.size() > 2), 16'h1);
			foreach (got[i])
				check("bad start entry", 16'(got[i]), (i == got.size() - 1) ? 16'h00 : 16'h3e);
			check("false carrier count", fcc, base + 16'(k + 1));
			fer_mac_model_inst.got.delete();
		end
		$display("done bad start");
	endtask

	initial
	begin
		repeat (8) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		@(posedge core_clk_in);
		t_link();
		t_lock();
		t_fill();
		t_halt();
		t_bad();
		close_out();
	end
endmodule

bind fer_rx_path fer_rx_path_chk #(
	.HOLD_CYCLES(HOLD_CYCLES),
	.LINK_CYCLES(LINK_CYCLES)
) fer_rx_path_chk_inst (
	.core_clk_in(core_clk_in), .resetn_in(resetn_in), .sym_valid_in(sym_valid_in), .sym_ready_out(sym_ready_out),
	.signal_detect_in(signal_detect_in), .link_pulse_in(link_pulse_in), .rx_valid_out(rx_valid_out),
	.mac_ready_in(mac_ready_in), .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out), .crs_out(crs_out),
	.rxd_out(rxd_out), .link_up_out(link_up_out), .pcs_enable_out(pcs_enable_out),
	.scr_locked_out(scr_locked_out), .false_carrier_event_counter_out(false_carrier_event_counter_out));
